// file: pkg/wiper_pkg.sv
// Summary of operation
// - shift read data out on falling clock
// - sample serial input on rising clock
// - pause input freezes sequence, state kept
// - deselected: output high impedance, standby once no preset write is running
// - ignore all until first select falling edge
// - write lock low blocks preset writes
// - serial output three-state unless reading
// - wiper value decoded one-hot to 256 taps
// - wiper loads: serial, preset, step, power-up
// - power-up loads wiper from preset zero
// - four 8-bit presets per wiper, transferable
// - preset write completes within 10 ms
// - read-only write-in-progress flag
// - first byte upper nibble is type code
// - execute only on full address match
// - second byte: opcode, preset select, wiper
// - opcode decode table
// - step mode moves wiper per clock pulse
package wiper_pkg;
    localparam logic [3:0] TYPE_CODE = 4'ha; // arbitrary value
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'ha;
    localparam logic [3:0] OP_RD_PRESET = 4'hb;
    localparam logic [3:0] OP_WR_PRESET = 4'hc;
    localparam logic [3:0] OP_PRESET_TO_WIPER = 4'hd;
    localparam logic [3:0] OP_WIPER_TO_PRESET = 4'he;
    localparam logic [3:0] OP_ALL_PRESET_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_ALL_WIPER_TO_PRESET = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [3:0] OP_RD_STATUS = 4'h5;
    localparam int NV_WRITE_MS = 10;
    localparam int CLK_MHZ = 125;
    localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;
    localparam logic [7:0] PRESET_RESET = 8'h80;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ID = 5'h02,
        ST_INSTR = 5'h04,
        ST_DATA = 5'h08,
        ST_IGNORE = 5'h10
    } seq_t;
endpackage

// file: hw/tap_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tap_decoder (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] position,
    output logic [255:0] taps
);
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            taps <= 256'h0;
        end else begin
            taps <= 256'h1 << position;
        end
    end
    taps_onehot_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(reset_n) |-> $onehot(taps))
        else $error("tap enables not one-hot");
endmodule
`default_nettype wire

// file: hw/dual_wiper_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_serial_control #(
    parameter int NV_WRITE_CYCLES = wiper_pkg::NV_WRITE_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    input wire logic [1:0] addr_strap_upper,
    output logic so,
    output logic so_oe,
    output logic write_in_progress_flag,
    output logic active,
    output logic [255:0] taps0,
    output logic [255:0] taps1
);
    ////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] cs_s, sck_s, si_s, hold_s, wp_s;
    logic sck_d1, cs_d1;
    logic [3:0] strap_s0, strap_s1;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            // select held low through reset must not look like an edge
            cs_s <= 2'h0;
            sck_s <= 2'h0;
            si_s <= 2'h0;
            hold_s <= 2'h3;
            wp_s <= 2'h0;
            sck_d1 <= 1'b0;
            cs_d1 <= 1'b0;
            strap_s0 <= 4'h0;
            strap_s1 <= 4'h0;
        end else begin
            cs_s <= {cs_s[0], cs_n};
            sck_s <= {sck_s[0], sck};
            si_s <= {si_s[0], si};
            hold_s <= {hold_s[0], hold_n};
            wp_s <= {wp_s[0], wp_n};
            sck_d1 <= sck_s[1];
            cs_d1 <= cs_s[1];
            strap_s0 <= {addr_strap_upper, addr_strap_high, addr_strap_low};
            strap_s1 <= strap_s0;
        end
    end
    wire logic cs_low = !cs_s[1];
    wire logic cs_fall = cs_d1 && !cs_s[1];
    // hold only changes while sck is low, so gating edges is enough
    wire logic run = cs_low && hold_s[1];
    wire logic sck_rise = run && sck_s[1] && !sck_d1;
    wire logic sck_fall = run && !sck_s[1] && sck_d1;

    ////////////////////////////////////////////////////////////////
    // sequence
    wiper_pkg::seq_t state_q;
    logic armed_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic [3:0] op_q;
    logic [1:0] sel_q;
    logic wsel_q;
    logic stepping_q;
    logic [7:0] out_q;
    logic reading_q;
    logic [7:0] wiper_q [2];
    logic [7:0] preset_q [2][4];
    logic [31:0] nv_cnt_q;
    logic recall_q;
    wire logic [7:0] byte_in = {shift_q[6:0], si_s[1]};
    wire logic byte_done = sck_rise && (bit_q == 3'h7);
    wire logic [3:0] addr_in = strap_s1;
    wire logic [3:0] iop = byte_in[7:4];
    wire logic nv_ok = wp_s[1] && (nv_cnt_q == 32'h0);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
        end else if (cs_fall) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= wiper_pkg::ST_IDLE;
            shift_q <= 8'h0;
            bit_q <= 3'h0;
            op_q <= 4'h0;
            sel_q <= 2'h0;
            wsel_q <= 1'b0;
            stepping_q <= 1'b0;
        end else if (!cs_low) begin
            state_q <= wiper_pkg::ST_IDLE;
            bit_q <= 3'h0;
            stepping_q <= 1'b0;
        end else begin
            case (state_q)
                wiper_pkg::ST_IDLE: begin
                    if (armed_q || cs_fall) begin
                        state_q <= wiper_pkg::ST_ID;
                    end
                end
                wiper_pkg::ST_ID, wiper_pkg::ST_INSTR, wiper_pkg::ST_DATA: begin
                    if (sck_rise && !stepping_q) begin
                        shift_q <= byte_in;
                        bit_q <= bit_q + 3'h1;
                    end
                    if (byte_done && !stepping_q) begin
                        if (state_q == wiper_pkg::ST_ID) begin
                            if (byte_in[7:4] == wiper_pkg::TYPE_CODE
                                && byte_in[3:0] == addr_in) begin
                                state_q <= wiper_pkg::ST_INSTR;
                            end else begin
                                state_q <= wiper_pkg::ST_IGNORE;
                            end
                        end else if (state_q == wiper_pkg::ST_INSTR) begin
                            op_q <= iop;
                            sel_q <= byte_in[3:2];
                            wsel_q <= byte_in[0];
                            state_q <= wiper_pkg::ST_DATA;
                            stepping_q <= (iop == wiper_pkg::OP_STEP);
                        end
                    end
                end
                wiper_pkg::ST_IGNORE: begin
                    state_q <= wiper_pkg::ST_IGNORE;
                end
                default: begin
                    state_q <= wiper_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // register actions
    wire logic instr_done = (state_q == wiper_pkg::ST_INSTR) && byte_done;
    wire logic data_done = (state_q == wiper_pkg::ST_DATA) && byte_done && !stepping_q;
    wire logic [1:0] isel = byte_in[3:2];
    wire logic iw = byte_in[0];
    logic nv_start;
    always_comb begin
        nv_start = 1'b0;
        if (nv_ok && instr_done && iop == wiper_pkg::OP_WIPER_TO_PRESET) begin
            nv_start = 1'b1;
        end
        if (nv_ok && instr_done && iop == wiper_pkg::OP_ALL_WIPER_TO_PRESET) begin
            nv_start = 1'b1;
        end
        if (nv_ok && data_done && op_q == wiper_pkg::OP_WR_PRESET) begin
            nv_start = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            recall_q <= 1'b1;
            for (int w = 0; w < 2; w++) begin
                wiper_q[w] <= 8'h0;
            end
        end else if (recall_q) begin
            recall_q <= 1'b0;
            for (int w = 0; w < 2; w++) begin
                wiper_q[w] <= preset_q[w][0];
            end
        end else if (instr_done && iop == wiper_pkg::OP_PRESET_TO_WIPER) begin
            wiper_q[iw] <= preset_q[iw][isel];
        end else if (instr_done && iop == wiper_pkg::OP_ALL_PRESET_TO_WIPER) begin
            for (int w = 0; w < 2; w++) begin
                wiper_q[w] <= preset_q[w][isel];
            end
        end else if (data_done && op_q == wiper_pkg::OP_WR_WIPER) begin
            wiper_q[wsel_q] <= byte_in;
        end else if (stepping_q && sck_rise) begin
            if (si_s[1] && wiper_q[wsel_q] != 8'hff) begin
                wiper_q[wsel_q] <= wiper_q[wsel_q] + 8'h1;
            end else if (!si_s[1] && wiper_q[wsel_q] != 8'h00) begin
                wiper_q[wsel_q] <= wiper_q[wsel_q] - 8'h1;
            end
        end
    end

    // preset array; reset stands in for the stored nonvolatile content
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int w = 0; w < 2; w++) begin
                for (int r = 0; r < 4; r++) begin
                    preset_q[w][r] <= wiper_pkg::PRESET_RESET;
                end
            end
        end else if (nv_ok && instr_done && iop == wiper_pkg::OP_WIPER_TO_PRESET) begin
            preset_q[iw][isel] <= wiper_q[iw];
        end else if (nv_ok && instr_done && iop == wiper_pkg::OP_ALL_WIPER_TO_PRESET) begin
            for (int w = 0; w < 2; w++) begin
                preset_q[w][isel] <= wiper_q[w];
            end
        end else if (nv_ok && data_done && op_q == wiper_pkg::OP_WR_PRESET) begin
            preset_q[wsel_q][sel_q] <= byte_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            nv_cnt_q <= 32'h0;
            write_in_progress_flag <= 1'b0;
        end else begin
            if (nv_start) begin
                nv_cnt_q <= 32'(NV_WRITE_CYCLES);
            end else if (nv_cnt_q != 32'h0) begin
                nv_cnt_q <= nv_cnt_q - 32'h1;
            end
            write_in_progress_flag <= nv_start || (nv_cnt_q > 32'h1);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            out_q <= 8'h0;
            reading_q <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
            active <= 1'b0;
        end else begin
            active <= cs_low || (nv_cnt_q != 32'h0);
            if (!cs_low || state_q == wiper_pkg::ST_IGNORE) begin
                reading_q <= 1'b0;
                so_oe <= 1'b0;
            end else if (instr_done) begin
                reading_q <= (iop == wiper_pkg::OP_RD_WIPER)
                    || (iop == wiper_pkg::OP_RD_PRESET)
                    || (iop == wiper_pkg::OP_RD_STATUS);
                case (iop)
                    wiper_pkg::OP_RD_WIPER: out_q <= wiper_q[iw];
                    wiper_pkg::OP_RD_PRESET: out_q <= preset_q[iw][isel];
                    default: out_q <= {7'h0, write_in_progress_flag};
                endcase
            end else if (reading_q && sck_fall) begin
                so <= out_q[7];
                so_oe <= 1'b1;
                out_q <= {out_q[6:0], 1'b0};
            end else if (data_done) begin
                reading_q <= 1'b0;
            end else if (!reading_q && sck_fall) begin
                so_oe <= 1'b0;
            end
        end
    end

    tap_decoder u_tap0 (
        .mclk(mclk),
        .reset_n(reset_n),
        .position(wiper_q[0]),
        .taps(taps0)
    );
    tap_decoder u_tap1 (
        .mclk(mclk),
        .reset_n(reset_n),
        .position(wiper_q[1]),
        .taps(taps1)
    );

    ////////////////////////////////////////////////////////////////
    // checks
    so_off_deselect_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cs_s[1] |=> !so_oe)
        else $error("serial output driven while deselected");
    no_start_unarmed_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !armed_q && !cs_fall |=> state_q == wiper_pkg::ST_IDLE)
        else $error("sequence started before select edge");
    lock_blocks_nv_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !wp_s[1] |-> !nv_start)
        else $error("nv write under write lock");
    wip_follows_a: assert property (@(posedge mclk) disable iff (!reset_n)
        nv_start |=> write_in_progress_flag)
        else $error("busy flag not raised");
    ignore_sticks_a: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == wiper_pkg::ST_IGNORE && cs_low |=> state_q == wiper_pkg::ST_IGNORE)
        else $error("ignored frame resumed");
    ignore_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == wiper_pkg::ST_IGNORE |=> !so_oe)
        else $error("output driven in ignored frame");
    hold_freeze_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cs_low && !hold_s[1] |=> $stable(bit_q))
        else $error("bit count moved during pause");
    recall_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
        recall_q |=> wiper_q[0] == $past(preset_q[0][0]))
        else $error("power-up recall wrong");
    step_up_a: assert property (@(posedge mclk) disable iff (!reset_n)
        stepping_q && sck_rise && si_s[1] && wiper_q[0] != 8'hff && !wsel_q && !recall_q
        |=> wiper_q[0] == $past(wiper_q[0]) + 8'h1)
        else $error("step up failed");
    so_on_fall_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(so_oe) |-> $past(sck_fall))
        else $error("output not on falling edge");
    read_cover_c: cover property (@(posedge mclk) disable iff (!reset_n) $rose(so_oe));
    nv_cover_c: cover property (@(posedge mclk) disable iff (!reset_n) nv_start);
    step_cover_c: cover property (@(posedge mclk) disable iff (!reset_n) stepping_q && sck_rise);
endmodule
`default_nettype wire

// file: dv/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input wire logic mclk,
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    // select starts low, so the first frame after power-up has no falling edge
    initial begin
        cs_n = 1'b0;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic open_frame();
        tick(1);
        cs_n = 1'b0;
        tick(4);
    endtask
    task automatic close_frame();
        tick(4);
        cs_n = 1'b1;
        si = ~si;
        tick(6);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // eight bits msb first; clock idles low, so sampled just before each fall
    task automatic xfer_byte(input logic [7:0] tx, input int hold_at, output logic [7:0] rx,
                             output logic oe_any);
        oe_any = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (i == hold_at) begin
                // let the last clock fall be seen before pausing
                tick(4);
                hold_n = 1'b0;
                si = ~si;
                tick(12);
                hold_n = 1'b1;
            end
            si = tx[i];
            tick(4);
            sck = 1'b1;
            tick(4);
            rx[i] = so;
            oe_any = oe_any | so_oe;
            sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: dv/dual_wiper_serial_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_serial_control_bench;
    localparam int NV_CYCLES = 400;
    localparam logic [7:0] ID_OK = {wiper_pkg::TYPE_CODE, 4'h9};
    localparam logic [7:0] ID_ADDR_BAD = {wiper_pkg::TYPE_CODE, 4'h1};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_oe, busy, active;
    logic [255:0] taps0, taps1;
    int mismatches = 0;
    int total_checks = 0;
`define check(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
    always #4 mclk = ~mclk;
    dual_wiper_serial_control #(.NV_WRITE_CYCLES(NV_CYCLES)) dut (.mclk(mclk),
        .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .addr_strap_low(1'b1), .addr_strap_high(1'b0), .addr_strap_upper(2'b10), .so(so),
        .so_oe(so_oe), .write_in_progress_flag(busy), .active(active), .taps0(taps0),
        .taps1(taps1));
    spi_master_model master (.mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [255:0] onehot(input logic [7:0] p);
        return 256'h1 << p;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // transfer ops carry two bytes, all others a third
    task automatic frame(input logic [7:0] id, input logic [3:0] op, input logic [1:0] ps,
                         input logic w, input logic [7:0] dat, input int hold_at,
                         output logic [7:0] rx, output logic oe);
        logic [7:0] r;
        logic o;
        rx = 8'h00;
        master.open_frame();
        master.xfer_byte(id, -1, r, oe);
        master.xfer_byte({op, ps, 1'b0, w}, hold_at, r, o);
        oe = oe | o;
        if (!(op inside {4'hd, 4'he, 4'h1, 4'h8})) begin
            master.xfer_byte(dat, -1, rx, o);
            oe = oe | o;
        end
        master.close_frame();
    endtask
    task automatic wr(input logic [7:0] id, input logic [3:0] op, input logic [1:0] ps,
                      input logic w, input logic [7:0] dat);
        logic [7:0] rx;
        logic oe;
        frame(id, op, ps, w, dat, -1, rx, oe);
        `check(oe, 1'b0)
    endtask
    task automatic rd(input logic [7:0] id, input logic [3:0] op, input logic [1:0] ps,
                      input logic w, input logic [7:0] exp, input logic exp_oe);
        logic [7:0] rx;
        logic oe;
        frame(id, op, ps, w, 8'h00, -1, rx, oe);
        `check(oe, exp_oe)
        if (exp_oe) begin
            `check(rx, exp)
        end
        `check(so_oe, 1'b0)
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
        #1;
        if (n == 1000) begin
            mismatches++;
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] rx;
        logic oe;
        repeat (12) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `check(taps0, onehot(wiper_pkg::PRESET_RESET))
        `check(taps1, onehot(8'h80))
        `check(so_oe, 1'b0)
        wr(ID_OK, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'h11);
        `check(taps0, onehot(8'h80))
        wr(ID_OK, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'h3c);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'h3c, 1'b1);
        `check(taps0, onehot(8'h3c))
        frame(ID_OK, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b1, 8'hc3, 3, rx, oe);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b1, 8'hc3, 1'b1);
        wr({4'h6, 4'h9}, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'h00);
        wr({wiper_pkg::TYPE_CODE, 4'h8}, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'h00);
        rd(ID_ADDR_BAD, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'h00, 1'b0);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'h3c, 1'b1);
        wr(ID_OK, wiper_pkg::OP_WR_PRESET, 2'd2, 1'b0, 8'ha5);
        `check(busy, 1'b1)
        `check(active, 1'b1)
        rd(ID_OK, wiper_pkg::OP_RD_STATUS, 2'd0, 1'b0, 8'h01, 1'b1);
        wait_idle();
        rd(ID_OK, wiper_pkg::OP_RD_STATUS, 2'd0, 1'b0, 8'h00, 1'b1);
        `check(active, 1'b0)
        rd(ID_OK, wiper_pkg::OP_RD_PRESET, 2'd2, 1'b0, 8'ha5, 1'b1);
        wp_n = 1'b0;
        wr(ID_OK, wiper_pkg::OP_WR_PRESET, 2'd2, 1'b0, 8'h11);
        wp_n = 1'b1;
        `check(busy, 1'b0)
        rd(ID_OK, wiper_pkg::OP_RD_PRESET, 2'd2, 1'b0, 8'ha5, 1'b1);
        wr(ID_OK, wiper_pkg::OP_PRESET_TO_WIPER, 2'd2, 1'b0, 8'h00);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'ha5, 1'b1);
        wr(ID_OK, wiper_pkg::OP_WIPER_TO_PRESET, 2'd1, 1'b1, 8'h00);
        wait_idle();
        rd(ID_OK, wiper_pkg::OP_RD_PRESET, 2'd1, 1'b1, 8'hc3, 1'b1);
        wr(ID_OK, wiper_pkg::OP_ALL_WIPER_TO_PRESET, 2'd3, 1'b0, 8'h00);
        wait_idle();
        wr(ID_OK, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'h00);
        wr(ID_OK, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b1, 8'h00);
        wr(ID_OK, wiper_pkg::OP_ALL_PRESET_TO_WIPER, 2'd3, 1'b0, 8'h00);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'ha5, 1'b1);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b1, 8'hc3, 1'b1);
        wr(ID_OK, wiper_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'hfc);
        wr(ID_OK, wiper_pkg::OP_STEP, 2'd0, 1'b0, 8'hf0);
        rd(ID_OK, wiper_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'hfb, 1'b1);
        `check(taps0, onehot(8'hfb))
        stop_test();
    end
endmodule
`default_nettype wire
